// file: idt_pkg.sv
// Package: constants, state encoding and carrier types of the descriptor transfer service
package idt_pkg;

  // Descriptor window in internal RAM, eight bytes per descriptor
  localparam logic [23:0] DESC_BASE = 24'h00_0100;
  localparam logic [23:0] DESC_LAST = 24'h00_017F;
  localparam int DESC_SHIFT = 3;
  // Word offsets inside a descriptor
  localparam logic [23:0] DESC_MODE_OFS = 24'h00_0000; // Low byte mode, high byte buffer upper
  localparam logic [23:0] DESC_BUF_OFS = 24'h00_0002; // Buffer pointer bits 15..0
  localparam logic [23:0] DESC_IO_OFS = 24'h00_0004; // I/O pointer
  localparam logic [23:0] DESC_CNT_OFS = 24'h00_0006; // Transfer counter

  // Mode byte field positions
  localparam int MODE_IO_HOLD = 4;
  localparam int MODE_WIDTH = 3;
  localparam int MODE_BUF_HOLD = 2;
  localparam int MODE_DIR = 1;
  localparam int MODE_STOP_EN = 0;
  localparam logic [7:0] MODE_USED_MASK = 8'h1F;

  // End status encodings
  localparam logic [1:0] END_RUNNING = 2'h0;
  localparam logic [1:0] END_COUNT = 2'h1;
  localparam logic [1:0] END_STOP = 2'h3;

  // Pointer steps
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // Software register offsets on the plain register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SERVICES = 4'h8;
  localparam int CTRL_ENABLE = 0;
  localparam logic CTRL_ENABLE_RST = 1'b1;

  // Service states, Gray coded along the usual path
  typedef enum logic [3:0] {
    IDT_IDLE = 4'b0000,
    IDT_RD_MODE = 4'b0001,
    IDT_RD_BUF = 4'b0011,
    IDT_RD_IO = 4'b0010,
    IDT_RD_CNT = 4'b0110,
    IDT_CHECK = 4'b0111,
    IDT_MOVE_RD = 4'b0101,
    IDT_MOVE_WR = 4'b0100,
    IDT_WB_CNT = 4'b1100,
    IDT_WB_IO = 4'b1101,
    IDT_WB_BUF = 4'b1111,
    IDT_FINISH = 4'b1110
  } idt_state_type;

  // Request from the interrupt controller for the winning source
  typedef struct packed {
    logic valid; // Winning request present
    logic service_select; // Source marked for descriptor service
    logic [5:0] source; // Winning source number
    logic [3:0] desc_index; // Descriptor slot from source_level_control
  } idt_req_type;

  // Memory master request
  typedef struct packed {
    logic req; // Access pending
    logic we; // Write when high
    logic word; // Word access when high
    logic [23:0] addr; // Byte address
    logic [15:0] wdata; // Write data
  } idt_mem_type;

  // Outcome pulses towards CPU and interrupt controller
  typedef struct packed {
    logic ordinary_irq; // Run the ordinary interrupt sequence
    logic clear_request; // Clear the peripheral request
    logic clear_select; // Clear service_select of the source
    logic branch_handler; // Enter the normal handler
    logic resume; // Resume the interrupted program
  } idt_evt_type;

endpackage

// file: idt_service.sv
// Descriptor transfer service engine driven by interrupt requests
//
// Contract
// - Interrupt request moves data without handler
// - No CPU working register used
// - Record end status, then branch to handler
// - Source level control gives descriptor location
// - Source level control selects service or interrupt
// - Descriptors live at 000100 to 00017F
// - Counter decremented before move; zero ends
// - Up to 65536 items per run
// - I/O pointer reaches only 000000 to 00FFFF
// - Buffer pointer is 24 bits wide
// - Each channel owns its buffer pointer
// - Mode bit 4: I/O pointer increments or holds
// - Mode bit 3: byte or word transfers
// - Mode bit 2: low 16 buffer bits step or hold
// - Mode bit 1 selects transfer direction
// - Mode bit 0 enables peripheral stop request
// - End status 00 run, 01 count, 11 stop
// - Select bit zero means ordinary interrupt
// - Other requests held pending during service
`timescale 1ns/1ps
module idt_service #(
  parameter int IDX_W = 4 // Descriptor index width
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire idt_pkg::idt_req_type irq_req, // Winning request from interrupt controller
  input wire logic stop_req, // Peripheral stop request
  input wire logic mem_ack, // Memory access done this cycle
  input wire logic [15:0] mem_rdata, // Read data, valid with mem_ack
  input wire logic [3:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output idt_pkg::idt_mem_type mem_out, // Memory master request
  output idt_pkg::idt_evt_type evt, // One-cycle outcome pulses
  output logic hold_pending, // Other requests must wait
  output logic [1:0] end_status // Last end condition
);
  import idt_pkg::*;

  // Index must keep every descriptor inside the RAM window
  if (IDX_W < 1 || IDX_W > 4) begin : g_chk
    $error("IDX_W must be 1 to 4");
  end

  // Whole module state
  typedef struct packed {
    idt_state_type st; // Sequencer state
    logic [7:0] mode; // Mode byte of the running descriptor
    logic [23:0] buf_ptr; // Buffer pointer, own per descriptor
    logic [15:0] io_ptr; // I/O pointer
    logic [15:0] cnt; // Transfer counter after decrement
    logic [15:0] data; // Internal data latch
    logic [IDX_W-1:0] idx; // Descriptor slot
    logic [5:0] source; // Source being serviced
    logic stopped; // Peripheral stop seen
    logic enable; // Service enable from control register
    logic [15:0] services; // Completed data moves
    logic busy; // Hold other requests
    logic [1:0] status; // End status
    idt_mem_type mem; // Memory request
    idt_evt_type evt; // Outcome pulses
    logic [31:0] rdata; // Register read data
  } idt_core_type;

  idt_core_type s;
  idt_core_type next_s;

  logic [23:0] desc_base; // Byte address of the descriptor
  logic [15:0] step; // Pointer step by width
  logic [23:0] io_addr; // Zero-extended I/O address
  logic [23:0] src_addr; // Move source address
  logic [23:0] dst_addr; // Move destination address
  logic accept_svc; // Descriptor service starts
  logic accept_irq; // Ordinary interrupt passes through

  // Descriptor slot scaled into the RAM window
  assign desc_base = DESC_BASE + {{(24-IDX_W-DESC_SHIFT){1'b0}}, s.idx, {DESC_SHIFT{1'b0}}};
  assign step = s.mode[MODE_WIDTH] ? STEP_WORD : STEP_BYTE;
  // Upper address byte of the I/O side is forced to zero
  assign io_addr = {8'h00, s.io_ptr};
  assign src_addr = s.mode[MODE_DIR] ? s.buf_ptr : io_addr;
  assign dst_addr = s.mode[MODE_DIR] ? io_addr : s.buf_ptr;
  // A new request is taken only when idle, so nothing nests
  assign accept_svc = (s.st == IDT_IDLE) && irq_req.valid && irq_req.service_select && s.enable;
  assign accept_irq = (s.st == IDT_IDLE) && irq_req.valid && !(irq_req.service_select && s.enable);

  // Next-state logic for sequencer, descriptor copy and registers
  always_comb begin
    next_s = s;
    next_s.evt = '0;
    next_s.rdata = 32'h0000_0000;
    // Register writes; status and counter are read only
    if (reg_wr && reg_addr == REG_CTRL) begin
      next_s.enable = reg_wdata[CTRL_ENABLE];
    end
    // Register reads, answer in the following cycle only
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: next_s.rdata = {31'h0000_0000, s.enable};
        REG_STATUS: next_s.rdata = {16'h0000, 2'h0, s.source, 3'h0, s.busy, 2'h0, s.status};
        REG_SERVICES: next_s.rdata = {16'h0000, s.services};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    case (s.st)
      IDT_IDLE: begin
        if (accept_svc) begin
          // Select bit set and service enabled: run the descriptor service
          next_s.busy = 1'b1;
          next_s.status = END_RUNNING;
          next_s.stopped = 1'b0;
          next_s.source = irq_req.source;
          next_s.idx = irq_req.desc_index[IDX_W-1:0];
          next_s.st = IDT_RD_MODE;
          next_s.mem = '{req: 1'b1, we: 1'b0, word: 1'b1,
                         addr: DESC_BASE + {{(24-IDX_W-DESC_SHIFT){1'b0}},
                                            irq_req.desc_index[IDX_W-1:0],
                                            {DESC_SHIFT{1'b0}}} + DESC_MODE_OFS,
                         wdata: 16'h0000};
        end else if (accept_irq) begin
          // Select bit clear or service disabled: ordinary interrupt sequence
          next_s.evt.ordinary_irq = 1'b1;
        end
      end
      IDT_RD_MODE: begin
        if (mem_ack) begin
          // Reserved mode bits are never trusted
          next_s.mode = mem_rdata[7:0] & MODE_USED_MASK;
          next_s.buf_ptr[23:16] = mem_rdata[15:8];
          next_s.mem.addr = desc_base + DESC_BUF_OFS;
          next_s.st = IDT_RD_BUF;
        end
      end
      IDT_RD_BUF: begin
        if (mem_ack) begin
          next_s.buf_ptr[15:0] = mem_rdata;
          next_s.mem.addr = desc_base + DESC_IO_OFS;
          next_s.st = IDT_RD_IO;
        end
      end
      IDT_RD_IO: begin
        if (mem_ack) begin
          next_s.io_ptr = mem_rdata;
          next_s.mem.addr = desc_base + DESC_CNT_OFS;
          next_s.st = IDT_RD_CNT;
        end
      end
      IDT_RD_CNT: begin
        if (mem_ack) begin
          // Decrement ahead of the move; zero wraps so 65536 items fit
          next_s.cnt = mem_rdata - CNT_ONE;
          next_s.mem.req = 1'b0;
          next_s.st = IDT_CHECK;
        end
      end
      IDT_CHECK: begin
        if (s.mode[MODE_STOP_EN] && stop_req) begin
          // Peripheral asked to stop; nothing is moved
          next_s.stopped = 1'b1;
          next_s.status = END_STOP;
          next_s.st = IDT_FINISH;
        end else begin
          next_s.mem = '{req: 1'b1, we: 1'b0, word: s.mode[MODE_WIDTH],
                         addr: src_addr, wdata: 16'h0000};
          next_s.st = IDT_MOVE_RD;
        end
      end
      IDT_MOVE_RD: begin
        if (mem_ack) begin
          // Data parks in a private latch, CPU registers stay untouched
          next_s.data = mem_rdata;
          next_s.mem = '{req: 1'b1, we: 1'b1, word: s.mode[MODE_WIDTH],
                         addr: dst_addr, wdata: mem_rdata};
          next_s.st = IDT_MOVE_WR;
        end
      end
      IDT_MOVE_WR: begin
        if (mem_ack) begin
          next_s.services = s.services + CNT_ONE;
          if (!s.mode[MODE_IO_HOLD]) begin
            next_s.io_ptr = s.io_ptr + step;
          end
          if (!s.mode[MODE_BUF_HOLD]) begin
            // Only the low half steps, carry never reaches the upper byte
            next_s.buf_ptr[15:0] = s.buf_ptr[15:0] + step;
          end
          next_s.mem = '{req: 1'b1, we: 1'b1, word: 1'b1,
                         addr: desc_base + DESC_CNT_OFS, wdata: s.cnt};
          next_s.st = IDT_WB_CNT;
        end
      end
      IDT_WB_CNT: begin
        if (mem_ack) begin
          next_s.mem.addr = desc_base + DESC_IO_OFS;
          next_s.mem.wdata = s.io_ptr;
          next_s.st = IDT_WB_IO;
        end
      end
      IDT_WB_IO: begin
        if (mem_ack) begin
          next_s.mem.addr = desc_base + DESC_BUF_OFS;
          next_s.mem.wdata = s.buf_ptr[15:0];
          next_s.st = IDT_WB_BUF;
        end
      end
      IDT_WB_BUF: begin
        if (mem_ack) begin
          next_s.mem.req = 1'b0;
          if (s.cnt == CNT_ZERO) begin
            next_s.status = END_COUNT;
          end
          next_s.st = IDT_FINISH;
        end
      end
      IDT_FINISH: begin
        // Status already stands; the branch follows it
        if (s.stopped || s.cnt == CNT_ZERO) begin
          next_s.evt.clear_select = 1'b1;
          next_s.evt.branch_handler = 1'b1;
        end else begin
          next_s.evt.clear_request = 1'b1;
          next_s.evt.resume = 1'b1;
        end
        next_s.busy = 1'b0;
        next_s.st = IDT_IDLE;
      end
      default: begin
        next_s.st = IDT_IDLE;
        next_s.mem.req = 1'b0;
        next_s.busy = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
      s.st <= IDT_IDLE;
      s.enable <= CTRL_ENABLE_RST;
      s.status <= END_RUNNING;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign reg_rdata = s.rdata;
  assign mem_out = s.mem;
  assign evt = s.evt;
  assign hold_pending = s.busy;
  assign end_status = s.status;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Named steps of the end of a service
  sequence end_pair_s;
    evt.branch_handler && evt.clear_select && !evt.resume;
  endsequence
  sequence stop_end_s;
    s.st == IDT_FINISH ##1 (end_pair_s and end_status == END_STOP);
  endsequence

  hold_busy_a: assert property (
    (s.st != IDT_IDLE) |-> hold_pending)
    else $error("service running without hold");
  io_upper_zero_a: assert property (
    (mem_out.req && (s.st == IDT_MOVE_RD || s.st == IDT_MOVE_WR) &&
     (mem_out.we == s.mode[MODE_DIR])) |-> mem_out.addr[23:16] == 8'h00)
    else $error("I/O access above 00FFFF");
  desc_window_a: assert property (
    (mem_out.req && s.st inside {IDT_RD_MODE, IDT_RD_BUF, IDT_RD_IO, IDT_RD_CNT,
                                 IDT_WB_CNT, IDT_WB_IO, IDT_WB_BUF}) |->
    (mem_out.addr >= DESC_BASE && mem_out.addr <= DESC_LAST))
    else $error("descriptor access outside window");
  buf_upper_a: assert property (
    (s.st inside {IDT_RD_IO, IDT_RD_CNT, IDT_CHECK, IDT_MOVE_RD, IDT_MOVE_WR,
                  IDT_WB_CNT, IDT_WB_IO, IDT_WB_BUF}) |-> $stable(s.buf_ptr[23:16]))
    else $error("buffer upper byte changed");
  ordinary_a: assert property (
    accept_irq |=> evt.ordinary_irq && !hold_pending)
    else $error("ordinary interrupt not raised");
  stop_path_a: assert property (
    (s.st == IDT_CHECK && s.mode[MODE_STOP_EN] && stop_req) |=> stop_end_s)
    else $error("stop request not honoured");
  width_a: assert property (
    (mem_out.req && s.st == IDT_MOVE_RD) |-> mem_out.word == s.mode[MODE_WIDTH])
    else $error("transfer width wrong");
  end_order_a: assert property (
    evt.branch_handler |-> (end_status != END_RUNNING) && ($past(end_status) == end_status))
    else $error("branch without end status");
  continue_a: assert property (
    (s.st == IDT_FINISH && !s.stopped && s.cnt != CNT_ZERO) |=>
    (evt.clear_request && evt.resume && !evt.branch_handler && end_status == END_RUNNING))
    else $error("continuing service not resumed");
  io_step_a: assert property (
    (s.st == IDT_MOVE_WR && mem_ack && !s.mode[MODE_IO_HOLD]) |=>
    s.io_ptr == $past(s.io_ptr) + $past(step))
    else $error("I/O pointer not stepped");

endmodule

// file: idt_mem_model.sv
// Partner model: byte RAM that answers the service's memory requests
`timescale 1ns/1ps
module idt_mem_model (
  input wire logic clk, // Clock
  input wire idt_pkg::idt_mem_type mem_out, // Request from the service
  input wire logic [1:0] wait_cyc, // Wait states before each ack
  output logic mem_ack = 1'b0, // Access done pulse
  output logic [15:0] mem_rdata = 16'h0000 // Read data with ack
);
  import idt_pkg::*;
  logic [7:0] mem [int]; // Sparse byte store, also loaded by the bench
  logic [1:0] wcnt = 2'h0; // Wait states spent
  logic [15:0] last = 16'h0000; // Last data returned

  // Unwritten bytes read as all ones
  function automatic logic [7:0] rd(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // One access at a time; the edge after an ack never acks again
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    // Outside an ack the data lines show no stale value
    mem_rdata <= ~last;
    if (mem_out.req && !mem_ack) begin
      if (wcnt < wait_cyc) begin
        wcnt <= wcnt + 2'h1;
      end else begin
        wcnt <= 2'h0;
        mem_ack <= 1'b1;
        if (mem_out.we) begin
          mem[mem_out.addr] = mem_out.wdata[7:0];
          if (mem_out.word) begin
            mem[mem_out.addr + 24'h1] = mem_out.wdata[15:8];
          end
        end else begin
          last = {mem_out.word ? rd(mem_out.addr + 24'h1) : 8'h00, rd(mem_out.addr)};
          mem_rdata <= last;
        end
      end
    end
  end
endmodule

// file: tb_interrupt_driven_io_transfer.sv
// Self-checking testbench of the descriptor transfer service
`timescale 1ns/1ps
module tb_interrupt_driven_io_transfer;
  import idt_pkg::*;
  logic clk = 1'b0; // 100 MHz clock
  logic rstn = 1'b0; // Reset, active low
  idt_req_type irq_req = '0; // Winning request
  logic stop_req = 1'b0; // Peripheral stop request
  logic mem_ack; // Memory done
  logic [15:0] mem_rdata; // Memory read data
  logic [3:0] reg_addr = 4'h0; // Register address
  logic [31:0] reg_wdata = 32'h0000_0000; // Register write data
  logic reg_wr = 1'b0; // Write strobe
  logic reg_rd = 1'b0; // Read strobe
  logic [31:0] reg_rdata; // Register read data
  idt_mem_type mem_out; // Memory request
  idt_evt_type evt; // Outcome pulses
  logic hold_pending; // Service busy
  logic [1:0] end_status; // End condition
  logic [1:0] wait_cyc = 2'h0; // Memory slowness
  int error_cnt = 0; // Mismatches
  int compares = 0; // Comparisons made
  int seed = 32'h0f2a_55e2; // Random seed
  int moves = 0; // Data moves expected
  logic rd_d = 1'b0; // Read strobe one cycle ago
  logic [31:0] reg_q[$]; // Expected read data
  logic [6:0] evt_q[$]; // Expected pulses and end status

  idt_service u_dut (.clk(clk), .rstn(rstn), .irq_req(irq_req), .stop_req(stop_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_out(mem_out), .evt(evt),
    .hold_pending(hold_pending), .end_status(end_status));
  idt_mem_model u_mem (.clk(clk), .mem_out(mem_out), .wait_cyc(wait_cyc),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // Clock generator
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic logic [15:0] get16(input logic [23:0] a);
    return {u_mem.mem[a + 24'h1], u_mem.mem[a]};
  endfunction

  function automatic void put16(input logic [23:0] a, input logic [15:0] v);
    u_mem.mem[a] = v[7:0];
    u_mem.mem[a + 24'h1] = v[15:8];
  endfunction

  // Register bus cycles, one strobe cycle each, then an idle edge so a
  // following call never assigns the same strobe twice in one time step
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    reg_q.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Monitor: results are matched against the oldest note
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) check("reg_rdata", reg_q.pop_front(), reg_rdata);
    // Pulses are unknown before the first reset edge, so only look once reset is out
    if (rstn && evt !== '0) check("evt_end", {25'h0, evt_q.pop_front()}, {25'h0, evt, end_status});
  end

  // Request that must end in an ordinary interrupt
  task automatic ordinary(input logic sel);
    @(posedge clk);
    evt_q.push_back({5'b10000, 2'b00});
    irq_req <= '{1'b1, sel, 6'h3F, 4'h0};
    @(posedge clk);
    irq_req.valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // One descriptor transfer with mode taken from the run number
  task automatic run_svc(input int i);
    logic [4:0] m;
    logic [3:0] idx;
    logic [15:0] io, bl, cnt, step;
    logic [7:0] bh, s0, s1;
    logic [23:0] base, src, dst;
    logic [31:0] r;
    logic stop;
    int k;
    m = i[4:0];
    idx = 4'(i * 7);
    base = DESC_BASE + {17'h0, idx, 3'b000};
    io = (i == 5) ? 16'hFFFF : {8'h20, 8'($random(seed))};
    bh = 8'hA5 ^ 8'(i);
    // Run 8 steps its buffer low half across the wrap point
    bl = (i == 8) ? 16'hFFFF : {4'h4, 12'($random(seed))};
    cnt = (i % 4 == 0) ? 16'h0001 : ((i % 4 == 1) ? 16'h0000 : 16'(i));
    r = $random(seed);
    stop = m[0] & r[0];
    step = m[3] ? STEP_WORD : STEP_BYTE;
    s0 = r[15:8];
    s1 = r[23:16];
    u_mem.mem[base] = {3'b000, m};
    u_mem.mem[base + 24'h1] = bh;
    put16(base + 24'h2, bl);
    put16(base + 24'h4, io);
    put16(base + 24'h6, cnt);
    src = m[1] ? {bh, bl} : {8'h00, io};
    dst = m[1] ? {8'h00, io} : {bh, bl};
    put16(src, {s1, s0});
    put16(dst, 16'h5A5A);
    if (stop) begin
      evt_q.push_back({5'b00110, 2'b11});
    end else begin
      moves++;
      evt_q.push_back((cnt == CNT_ONE) ? {5'b00110, 2'b01} : {5'b01001, 2'b00});
    end
    stop_req <= r[0];
    wait_cyc <= 2'(i);
    irq_req <= '{1'b1, 1'b1, 6'(i), idx};
    for (k = 0; k < 20 && hold_pending !== 1'b1; k++) @(posedge clk);
    check("hold_pending", 32'h0000_0001, {31'h0000_0000, hold_pending});
    irq_req.valid <= 1'b0;
    for (k = 0; k < 400 && evt === '0; k++) @(posedge clk);
    // A service that never ends counts as a mismatch
    if (evt === '0) error_cnt++;
    stop_req <= 1'b0;
    check("count", {16'h0, stop ? cnt : cnt - CNT_ONE}, {16'h0, get16(base + 24'h6)});
    check("io_ptr", {16'h0, (stop || m[4]) ? io : io + step}, {16'h0, get16(base + 24'h4)});
    check("buf_ptr", {8'h0, bh, (stop || m[2]) ? bl : bl + step},
      {8'h0, u_mem.mem[base + 24'h1], get16(base + 24'h2)});
    check("data", {16'h0, (stop || !m[3]) ? 8'h5A : s1, stop ? 8'h5A : s0},
      {16'h0, get16(dst)});
    reg_read(REG_STATUS, {18'h0, 6'(i), 6'h00, stop ? 2'b11 : ((cnt == CNT_ONE) ? 2'b01 : 2'b00)});
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    reg_read(REG_CTRL, 32'h0000_0001);
    reg_read(REG_STATUS, 32'h0000_0000);
    reg_read(4'hC, 32'h0000_0000);
    reg_write(REG_STATUS, 32'hFFFF_FFFF);
    reg_read(REG_STATUS, 32'h0000_0000);
    ordinary(1'b0);
    reg_write(REG_CTRL, 32'h0000_0000);
    ordinary(1'b1);
    reg_write(REG_CTRL, 32'h0000_0001);
    for (int i = 0; i < 32; i++) run_svc(i);
    reg_read(REG_SERVICES, 32'(moves));
    repeat (3) @(posedge clk);
    check("events_left", 32'h0000_0000, 32'(evt_q.size()));
    end_sim;
  end

  // Watchdog, far beyond the expected run of under two thousand cycles
  initial begin
    #200_000;
    error_cnt++;
    end_sim;
  end
endmodule
